/* design/ocp_channel.sv */
// Overview of operation
// - modes 001/010/011 force low, high, toggle
// - simple modes compare primary against timer count
// - wrap without match leaves pin unchanged
// - 100 single pulse, 101 continuous pulses
// - primary starts pulse, secondary stops it
// - single pulse rearms only on mode rewrite
// - pwm: primary is read-only active duty latch
// - mode 111 low fault tristates the pin
// - fault status at control bit 4
// - fault holds until cleared and mode rewritten
// - pwm period follows timer period plus one
// - period rollover sets pin, reloads duty, flags timer
// - zero duty keeps pin low
// - duty above period keeps pin high
// - sleep holds pin level, resumes on wake
// - idle runs only if both stop bits clear, timer on
// - non-pwm compare sets channel flag, software clears
// - pwm sets timer flag, never channel flag
// - control bit 3 selects second timer
module ocp_channel #(
	parameter int CNT_WIDTH = ocp_pkg::CNT_W
)(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [15:0] ctl_wdata,
	input wire logic ctl_we,
	input wire logic [CNT_WIDTH-1:0] primary_wdata,
	input wire logic primary_we,
	input wire logic [CNT_WIDTH-1:0] secondary_wdata,
	input wire logic secondary_we,
	input wire ocp_pkg::ocp_timer_s timer_a,
	input wire ocp_pkg::ocp_timer_s timer_b,
	input wire logic cpu_sleep,
	input wire logic cpu_idle,
	input wire logic fault_input_pin_b,
	input wire logic compare_irq_enable,
	input wire logic compare_irq_clear,
	output logic [15:0] channel_control_word,
	output logic [CNT_WIDTH-1:0] primary_compare_value,
	output logic [CNT_WIDTH-1:0] secondary_compare_value,
	output logic compare_output_pin_o,
	output logic compare_output_pin_oe,
	output logic compare_irq_flag,
	output logic compare_irq,
	output logic first_timer_irq_set,
	output logic second_timer_irq_set
);
	logic [2:0] mode_r;
	logic tsel_r;
	logic sidl_r;
	logic fault_r;
	logic [CNT_WIDTH-1:0] pri_r;
	logic [CNT_WIDTH-1:0] sec_r;
	logic pin_r;
	logic oe_r;
	logic flag_r;
	logic irq_r;
	logic t1_set_r;
	logic t2_set_r;
	logic [CNT_WIDTH-1:0] cnt_prev_r;
	ocp_pkg::ocp_pulse_e pulse_r;

	ocp_pkg::ocp_timer_s tb;
	logic [CNT_WIDTH-1:0] cnt;
	logic active;
	logic advanced;
	logic rollover;
	logic is_pwm;
	logic pri_hit;
	logic sec_hit;
	logic cmp_event;

	function automatic logic is_pwm_mode(input logic [2:0] m);
		is_pwm_mode = (m == ocp_pkg::MODE_PWM) || (m == ocp_pkg::MODE_PWM_FLT);
	endfunction

	function automatic logic is_simple_mode(input logic [2:0] m);
		is_simple_mode = (m == ocp_pkg::MODE_LOW) || (m == ocp_pkg::MODE_HIGH) || (m == ocp_pkg::MODE_TOGGLE);
	endfunction

	function automatic logic is_dual_mode(input logic [2:0] m);
		is_dual_mode = (m == ocp_pkg::MODE_SINGLE) || (m == ocp_pkg::MODE_CONT);
	endfunction

	// sleep freezes count tracking, compare events and the pin; idle needs both stop bits clear and the timer on
	always_comb
	begin
		tb = tsel_r ? timer_b : timer_a;
		cnt = tb.count[CNT_WIDTH-1:0];
		active = !cpu_sleep && (!cpu_idle || (!sidl_r && tb.run && !tb.idle_stop));
		advanced = active && (cnt != cnt_prev_r);
	end

	// count back to zero after sitting at the period value is the rollover
	always_comb
	begin
		rollover = advanced && (cnt == '0) && (cnt_prev_r == tb.period[CNT_WIDTH-1:0]);
		is_pwm = is_pwm_mode(mode_r);
		pri_hit = advanced && (cnt == pri_r);
		sec_hit = advanced && (cnt == sec_r);
	end

	// a dual event only counts in the pulse phase that expects it
	always_comb
	begin
		cmp_event = 1'b0;
		if (is_simple_mode(mode_r))
		begin
			cmp_event = pri_hit;
		end
		else if (is_dual_mode(mode_r))
		begin
			cmp_event = (pri_hit && pulse_r == ocp_pkg::OCP_WAIT_START)
				|| (sec_hit && pulse_r == ocp_pkg::OCP_WAIT_STOP);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			cnt_prev_r <= '0;
		end
		else if (active)
		begin
			cnt_prev_r <= cnt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			mode_r <= ocp_pkg::CTL_RESET[ocp_pkg::CTL_MODE_LSB +: 3];
			tsel_r <= ocp_pkg::CTL_RESET[ocp_pkg::CTL_TSEL_BIT];
			sidl_r <= ocp_pkg::CTL_RESET[ocp_pkg::CTL_SIDL_BIT];
		end
		else if (ctl_we)
		begin
			mode_r <= ctl_wdata[ocp_pkg::CTL_MODE_LSB +: 3];
			tsel_r <= ctl_wdata[ocp_pkg::CTL_TSEL_BIT];
			sidl_r <= ctl_wdata[ocp_pkg::CTL_SIDL_BIT];
		end
	end

	// fault: sticky until input high and mode rewritten
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			fault_r <= 1'b0;
		end
		else if (mode_r == ocp_pkg::MODE_PWM_FLT && !fault_input_pin_b)
		begin
			fault_r <= 1'b1;
		end
		else if (ctl_we && fault_input_pin_b)
		begin
			fault_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sec_r <= ocp_pkg::VAL_RESET[CNT_WIDTH-1:0];
		end
		else if (secondary_we)
		begin
			sec_r <= secondary_wdata;
		end
	end

	// software writes to the primary are ignored while pwm owns the latch
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pri_r <= ocp_pkg::VAL_RESET[CNT_WIDTH-1:0];
		end
		else if (is_pwm && rollover)
		begin
			pri_r <= sec_r;
		end
		else if (primary_we && !is_pwm)
		begin
			pri_r <= primary_wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pulse_r <= ocp_pkg::OCP_IDLE;
		end
		else if (ctl_we)
		begin
			pulse_r <= ocp_pkg::OCP_WAIT_START;
		end
		else
		begin
			case (pulse_r)
				ocp_pkg::OCP_WAIT_START:
				begin
					if (pri_hit)
						pulse_r <= ocp_pkg::OCP_WAIT_STOP;
				end
				ocp_pkg::OCP_WAIT_STOP:
				begin
					if (sec_hit)
						pulse_r <= (mode_r == ocp_pkg::MODE_CONT) ? ocp_pkg::OCP_WAIT_START
							: ocp_pkg::OCP_DONE;
				end
				ocp_pkg::OCP_DONE:
				begin
					pulse_r <= ocp_pkg::OCP_DONE;
				end
				default:
				begin
					pulse_r <= ocp_pkg::OCP_IDLE;
				end
			endcase
		end
	end

	// pin holds its level unless an event acts; covers wrap and sleep
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pin_r <= 1'b0;
		end
		else if (active)
		begin
			case (mode_r)
				ocp_pkg::MODE_LOW:
				begin
					if (pri_hit)
						pin_r <= 1'b0;
				end
				ocp_pkg::MODE_HIGH:
				begin
					if (pri_hit)
						pin_r <= 1'b1;
				end
				ocp_pkg::MODE_TOGGLE:
				begin
					if (pri_hit)
						pin_r <= !pin_r;
				end
				ocp_pkg::MODE_SINGLE, ocp_pkg::MODE_CONT:
				begin
					if (pri_hit && pulse_r == ocp_pkg::OCP_WAIT_START)
						pin_r <= 1'b1;
					else if (sec_hit && pulse_r == ocp_pkg::OCP_WAIT_STOP)
						pin_r <= 1'b0;
				end
				ocp_pkg::MODE_PWM, ocp_pkg::MODE_PWM_FLT:
				begin
					// rollover wins so a nonzero new duty sets the pin high even when the old duty latch was zero
					if (rollover)
						pin_r <= (sec_r != '0);
					else if (pri_hit)
						pin_r <= 1'b0;
				end
				default:
				begin
					pin_r <= pin_r;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			oe_r <= 1'b0;
		end
		else
		begin
			oe_r <= (mode_r != ocp_pkg::MODE_OFF) && !fault_r
				&& !(mode_r == ocp_pkg::MODE_PWM_FLT && !fault_input_pin_b);
		end
	end

	// set wins over a same-cycle clear
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			flag_r <= 1'b0;
		end
		else if (cmp_event && !is_pwm)
		begin
			flag_r <= 1'b1;
		end
		else if (compare_irq_clear)
		begin
			flag_r <= 1'b0;
		end
	end

	// irq trails the flag by one cycle; costs latency, keeps one source
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			irq_r <= 1'b0;
		end
		else
		begin
			irq_r <= compare_irq_enable && flag_r;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			t1_set_r <= 1'b0;
			t2_set_r <= 1'b0;
		end
		else
		begin
			t1_set_r <= is_pwm && rollover && !tsel_r;
			t2_set_r <= is_pwm && rollover && tsel_r;
		end
	end

	logic [15:0] ccw_v;
	always_comb
	begin
		ccw_v = ocp_pkg::CTL_RESET;
		ccw_v[ocp_pkg::CTL_MODE_LSB +: 3] = mode_r;
		ccw_v[ocp_pkg::CTL_TSEL_BIT] = tsel_r;
		ccw_v[ocp_pkg::CTL_FLT_BIT] = fault_r;
		ccw_v[ocp_pkg::CTL_SIDL_BIT] = sidl_r;
	end

	assign channel_control_word = ccw_v;
	assign primary_compare_value = pri_r;
	assign secondary_compare_value = sec_r;
	assign compare_output_pin_o = pin_r;
	assign compare_output_pin_oe = oe_r;
	assign compare_irq_flag = flag_r;
	assign compare_irq = irq_r;
	assign first_timer_irq_set = t1_set_r;
	assign second_timer_irq_set = t2_set_r;
endmodule

/* design/ocp_pkg.sv */
package ocp_pkg;
	localparam int CNT_W = 16;
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_LOW = 3'h1;
	localparam logic [2:0] MODE_HIGH = 3'h2;
	localparam logic [2:0] MODE_TOGGLE = 3'h3;
	localparam logic [2:0] MODE_SINGLE = 3'h4;
	localparam logic [2:0] MODE_CONT = 3'h5;
	localparam logic [2:0] MODE_PWM = 3'h6;
	localparam logic [2:0] MODE_PWM_FLT = 3'h7;
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_TSEL_BIT = 3;
	localparam int CTL_FLT_BIT = 4;
	localparam int CTL_SIDL_BIT = 13;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [15:0] VAL_RESET = 16'h0000;
	localparam int OSC_PER_TCY = 4;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] period;
		logic run;
		logic idle_stop;
	} ocp_timer_s;

	typedef enum logic [1:0] {
		OCP_IDLE,
		OCP_WAIT_START,
		OCP_WAIT_STOP,
		OCP_DONE
	} ocp_pulse_e;
endpackage

/* dv/ocp_asserts.sv */
module ocp_asserts #(
	parameter int CNT_WIDTH = ocp_pkg::CNT_W
)(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ctl_we,
	input wire ocp_pkg::ocp_timer_s timer_a,
	input wire logic cpu_sleep,
	input wire logic cpu_idle,
	input wire logic fault_input_pin_b,
	input wire logic compare_irq_enable,
	input wire logic compare_irq_clear,
	input wire logic [15:0] channel_control_word,
	input wire logic [CNT_WIDTH-1:0] primary_compare_value,
	input wire logic compare_output_pin_o,
	input wire logic compare_output_pin_oe,
	input wire logic compare_irq_flag,
	input wire logic compare_irq,
	input wire logic first_timer_irq_set,
	input wire logic second_timer_irq_set
);
	timeunit 1ns / 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	wire logic live = !cpu_sleep && !cpu_idle && !ctl_we;
	wire logic [3:0] md = channel_control_word[3:0];
	a_match_low:
	assert property (live && md == 4'h1 && timer_a.run && $changed(timer_a.count)
		&& timer_a.count == primary_compare_value |=> !compare_output_pin_o) else $error("pin not low");
	a_fault_tri:
	assert property (live && md[2:0] == 3'h7 && !fault_input_pin_b
		|=> !compare_output_pin_oe && channel_control_word[4]) else $error("fault missed");
	a_pwm_noflag:
	assert property (md[2:1] == 2'h3 && !compare_irq_flag && !ctl_we |=> !compare_irq_flag) else $error("pwm flag");
	a_flag_sticky:
	assert property (compare_irq_flag && !compare_irq_clear |=> compare_irq_flag) else $error("flag lost");
	a_irq_gate:
	assert property (compare_irq == $past(compare_irq_flag && compare_irq_enable)) else $error("irq gate");
	a_tmr_pulse:
	assert property (first_timer_irq_set && !channel_control_word[4] |-> md[2:1] == 2'h3
		&& compare_output_pin_o == (primary_compare_value != 16'h0) ##1 !first_timer_irq_set) else $error("rollover");
	a_tsel_route:
	assert property (second_timer_irq_set |-> md[3] && !first_timer_irq_set) else $error("timer route");
	a_sleep_hold:
	assert property (cpu_sleep |=> $stable(compare_output_pin_o) && $stable(compare_output_pin_oe)) else $error("sleep");
	cover property (first_timer_irq_set);
	cover property (second_timer_irq_set);
	cover property (channel_control_word[4]);
endmodule
bind ocp_channel ocp_asserts #(.CNT_WIDTH(CNT_WIDTH)) ocp_asserts_i (.clk, .rst_b, .ctl_we, .timer_a, .cpu_sleep,
	.cpu_idle, .fault_input_pin_b, .compare_irq_enable, .compare_irq_clear, .channel_control_word,
	.primary_compare_value, .compare_output_pin_o, .compare_output_pin_oe, .compare_irq_flag, .compare_irq,
	.first_timer_irq_set, .second_timer_irq_set);

/* dv/ocp_load.sv */
module ocp_load (
	input wire logic pin_o,
	input wire logic pin_oe,
	input wire logic flt,
	output logic pad,
	output logic fault_b
);
	timeunit 1ns / 1ps;
	logic last = 1'b0;
	always @(pin_o)
		last = pin_o;
	// released pad shows the inverse so a stale level never passes
	assign pad = pin_oe ? pin_o : ~last;
	assign fault_b = ~flt;
endmodule

/* dv/tb_top.sv */
module tb_top;
	timeunit 1ns / 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] wd = 16'h0000;
	logic [2:0] we = 3'h0;
	ocp_pkg::ocp_timer_s ta = {16'h0000, 16'h000F, 1'h1, 1'h0};
	logic slp = 1'b0, idl = 1'b0, flt = 1'b0, clr = 1'b0, ien = 1'b1;
	logic [15:0] ccw, pv, sv;
	logic po, poe, flag, irq, t1, t2, pad, fb;
	logic [31:0] seed = 32'h00000033;
	logic [18:0] q [$];
	int bad_count = 0;
	int checks_done = 0;
	string nm [8] = '{"pin", "oe", "flag", "irq", "ctl", "primary", "t1", "t2"};
	ocp_channel ocp_channel_i (.clk, .rst_b, .ctl_wdata(wd), .ctl_we(we[0]), .primary_wdata(wd), .primary_we(we[1]),
		.secondary_wdata(wd), .secondary_we(we[2]), .timer_a(ta), .timer_b(ta), .cpu_sleep(slp), .cpu_idle(idl),
		.fault_input_pin_b(fb), .compare_irq_enable(ien), .compare_irq_clear(clr), .channel_control_word(ccw),
		.primary_compare_value(pv), .secondary_compare_value(sv), .compare_output_pin_o(po),
		.compare_output_pin_oe(poe), .compare_irq_flag(flag), .compare_irq(irq), .first_timer_irq_set(t1),
		.second_timer_irq_set(t2));
	ocp_load ocp_load_i (.pin_o(po), .pin_oe(poe), .flt, .pad, .fault_b(fb));
	initial
	begin
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic [15:0] obs(logic [2:0] k);
		logic [15:0] v [8];
		v = '{{15'h0, po}, {15'h0, poe}, {15'h0, flag}, {15'h0, irq}, ccw, pv, {15'h0, t1}, {15'h0, t2}};
		return v[k];
	endfunction
	task automatic ex(logic [2:0] k, logic [15:0] v);
		q.push_back({k, v});
	endtask
	task automatic print_verdict;
		if (bad_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(string name, logic [15:0] seen, logic [15:0] expv);
		checks_done++;
		if (seen !== expv)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, expv, seen);
		end
	endtask
	always @(negedge clk)
		while (q.size() > 0)
		begin
			logic [18:0] n;
			n = q.pop_front();
			chk(nm[n[18:16]], obs(n[18:16]), n[15:0]);
		end
	// one shared data bus; we picks control, primary or secondary
	task automatic wr(int k, logic [15:0] v);
		@(posedge clk);
		wd <= v;
		we <= 3'(1 << k);
		@(posedge clk);
		we <= 3'h0;
	endtask
	task automatic tk(logic [15:0] c);
		@(posedge clk);
		ta.count <= c;
		@(posedge clk);
	endtask
	task automatic cl;
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	initial
	begin
		repeat (5000) @(posedge clk);
		bad_count++;
		print_verdict();
	end
	initial
	begin
		logic [15:0] p;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		ex(4, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			seed = xs(seed);
			p = 16'h0002 + 16'(seed[2:0]);
			ien <= 1'(i != 3);
			wr(1, p);
			wr(0, i == 0 ? 16'h0002 : 16'(i == 1 ? 1 : 3));
			tk(p - 16'h0001);
			tk(16'h0000);
			ex(0, 16'(i % 2));
			tk(p);
			ex(0, 16'(1 - i % 2));
			ex(2, 16'h0001);
			@(posedge clk);
			ex(3, 16'(i != 3));
			cl();
			ex(2, 16'h0000);
		end
		wr(0, 16'h2003);
		idl <= 1'b1;
		tk(16'h0000);
		tk(p);
		ex(0, 16'h0000);
		idl <= 1'b0;
		wr(0, 16'h0003);
		idl <= 1'b1;
		tk(16'h0000);
		tk(p);
		ex(0, 16'h0001);
		idl <= 1'b0;
		slp <= 1'b1;
		tk(16'h0000);
		tk(p);
		ex(0, 16'h0001);
		slp <= 1'b0;
		tk(16'h0000);
		wr(1, 16'h0003);
		wr(2, 16'h0006);
		wr(0, 16'h0004);
		tk(16'h0003);
		ex(0, 16'h0001);
		tk(16'h0006);
		ex(0, 16'h0000);
		tk(16'h0000);
		tk(16'h0003);
		ex(0, 16'h0000);
		for (int m = 4; m < 6; m++)
		begin
			wr(0, 16'(m));
			tk(16'h0000);
			tk(16'h0003);
			ex(0, 16'h0001);
			tk(16'h0006);
			ex(0, 16'h0000);
		end
		tk(16'h0000);
		tk(16'h0003);
		ex(0, 16'h0001);
		cl();
		ta.period <= 16'h0009;
		wr(2, 16'h0004);
		wr(0, 16'h0006);
		wr(1, 16'h0007);
		ex(5, 16'h0003);
		tk(16'h0009);
		tk(16'h0000);
		ex(0, 16'h0001);
		ex(5, 16'h0004);
		ex(6, 16'h0001);
		tk(16'h0004);
		ex(0, 16'h0000);
		ex(2, 16'h0000);
		wr(2, 16'h0000);
		tk(16'h0009);
		tk(16'h0000);
		ex(0, 16'h0000);
		wr(2, 16'h000C);
		tk(16'h0009);
		tk(16'h0000);
		tk(16'h0004);
		tk(16'h0009);
		ex(0, 16'h0001);
		wr(0, 16'h000E);
		tk(16'h0000);
		ex(7, 16'h0001);
		wr(0, 16'h0007);
		flt <= 1'b1;
		@(posedge clk);
		ex(1, 16'h0000);
		ex(4, 16'h0017);
		wr(0, 16'h0007);
		flt <= 1'b0;
		tk(16'h0009);
		tk(16'h0000);
		ex(1, 16'h0000);
		wr(0, 16'h0007);
		tk(16'h0009);
		tk(16'h0000);
		ex(1, 16'h0001);
		@(posedge clk);
		print_verdict();
	end
endmodule
